// ==== logic/pbfsm_consts.vh ====
// Timing constants and state codes for the pushbutton power on/off sequencer.
// Assumes a 100 MHz system clock; every ms interval is built from a 1 ms tick, the 30 us request filter counts clock cycles.
//
// Overview of operation
// [RULE1] Turn-on by key: supply sense ignored, even its fall, until key pressed again.
// [RULE2] Turn-on by supply sense: key press or sense fall both start turn-off.
// [RULE3] Reduced-pin configuration: sense fall never starts a turn-off.
// [RULE4] Simultaneous key fall and sense rise: key wins, run its 32 ms debounce.
// [RULE5] During that debounce ignore sense, unless key bounces high first.
// [RULE6] Sense high at power-up: switch on after about one second, no press.
// [RULE7] After key turn-off with sense high, need new sense rise or key press.
// [RULE8] User forces off by holding key 64 ms plus the adjustable delay.
// [RULE9] Forced-off delay is a configurable count standing in for the timing capacitor.
// [RULE10] Sense-started turn-off forced delay is 32 ms shorter, no initial debounce.
// [RULE11] Zero timer setting: forced delay 64 ms for key, 32 ms for sense.
// [RULE12] Shutdown request low quickly drops the supply switch output.
// [RULE13] Shutdown request acts only when held low at least 30 us.
// [RULE14] Output polarity selectable: active high or active low switch drive.
// [RULE15] Key turn-on only after key held low 32 ms without interruption.
// [RULE16] After turn-on ignore inputs 512 ms; request must be high by then.
// [RULE17] After switch off and key release, one second lockout ignoring key and sense.
// [RULE18] Forced-off timer counts 16 oscillator periods, then forces off, releases irq.
// [RULE19] All intervals from one slow tick via counters; edges taken after sync. The request filter counts sys_clk cycles instead.
`ifndef PBFSM_CONSTS_VH
`define PBFSM_CONSTS_VH

// -----------------------------------------------------------------
// Clock and tick
// -----------------------------------------------------------------
`define PBFSM_CLK_NS 10
`define PBFSM_TICK_NS 1000000
// One 1 ms tick of 10 ns cycles, sized to fit the 17-bit prescaler
`define PBFSM_TICK_CYCLES 17'd100000

// -----------------------------------------------------------------
// Intervals in ms ticks
// -----------------------------------------------------------------
`define PBFSM_DEBOUNCE_MS 20'd32
`define PBFSM_IRQ_MIN_MS 20'd32
`define PBFSM_ON_BLANK_MS 20'd512
`define PBFSM_LOCKOUT_MS 20'd1000
// Sixteen oscillator periods, applied as a shift of the delay setting
`define PBFSM_FORCE_SHIFT 4
// Capacitor scale the delay setting replaces, in nF per second
`define PBFSM_FORCE_NF_PER_S 190

// -----------------------------------------------------------------
// Shutdown request glitch filter
// -----------------------------------------------------------------
`define PBFSM_KILL_MIN_NS 30000
`define PBFSM_KILL_CYCLES ((`PBFSM_KILL_MIN_NS + `PBFSM_CLK_NS - 1) / `PBFSM_CLK_NS)
`define PBFSM_KILL_W 12

// -----------------------------------------------------------------
// State codes
// -----------------------------------------------------------------
`define PBFSM_S_PWRUP 4'h0
`define PBFSM_S_OFF 4'h1
`define PBFSM_S_ON_DEB 4'h2
`define PBFSM_S_BLANK 4'h3
`define PBFSM_S_RUN 4'h4
`define PBFSM_S_OFF_DEB 4'h5
`define PBFSM_S_IRQ_MIN 4'h6
`define PBFSM_S_FORCE 4'h7
`define PBFSM_S_HOLD 4'h8
`define PBFSM_S_LOCK 4'h9

`endif

// ==== logic/pbfsm_timer.v ====
// Interval timer counting 1 ms ticks up to a loaded limit.
// Assumes the tick is a one-cycle pulse in the sys_clk domain.
`timescale 1ns/1ps

module pbfsm_timer (
  input wire sys_clk,
  input wire sys_rst,
  input wire start,
  input wire tick,
  input wire [19:0] limit,
  output reg done
);
  reg [19:0] count;
  reg [19:0] target;

  // -----------------------------------------------------------------
  // Counter
  // -----------------------------------------------------------------
  // Load restarts from zero; a zero limit reports done at once
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      count <= 20'h00000;
      target <= 20'h00000;
      done <= 1'b0;
    end else if (start) begin
      count <= 20'h00000;
      target <= limit;
      done <= (limit == 20'h00000);
    end else if (tick && !done) begin
      count <= count + 20'h00001; // RULE19
      done <= (count + 20'h00001 >= target);
    end
  end
endmodule // pbfsm_timer

// ==== logic/pbfsm_sequencer.v ====
// Pushbutton power on/off sequencer: debounce, blanking, lockout and forced-off logic.
// Assumes key, sense and request asynchronous to sys_clk; the host answers on shutdownRequestN.
`timescale 1ns/1ps
`include "pbfsm_consts.vh"

module pbfsm_sequencer #(
  parameter [16:0] TICK_CYCLES = `PBFSM_TICK_CYCLES
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire pushKeyN,
  input wire auxSupplySense,
  input wire shutdownRequestN,
  input wire auxFalloffAllow,
  input wire reducedPin,
  input wire activeLowOut,
  input wire [15:0] forcedOffDelay,
  output reg supplySwitchOut,
  output reg powerIrqN,
  output reg auxGood
);
  reg [2:0] sync1;
  reg [2:0] sync2;
  reg [2:0] prev;
  reg [16:0] prescale;
  reg tick;
  reg [`PBFSM_KILL_W-1:0] killCount;
  reg killLow;
  reg [3:0] state;
  reg switchOn;
  reg byAux;
  reg offByAux;
  reg auxPend;
  reg ivlStart;
  reg [19:0] ivlLimit;
  wire ivlDone;
  wire [2:0] raw;
  wire keyLow;
  wire auxHigh;
  wire keyFall;
  wire auxRise;
  wire auxFall;
  wire ivlEnd;
  wire auxOffOk;
  wire [19:0] forcedLimit;

  // -----------------------------------------------------------------
  // Input synchronisers and edge detection
  // -----------------------------------------------------------------
  assign raw = {shutdownRequestN, auxSupplySense, pushKeyN};

  // Two stages per input plus a delayed copy; the second stage and that copy feed the logic
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : gSync
      always @(posedge sys_clk) begin
        if (sys_rst) begin
          sync1[gi] <= 1'b1;
          sync2[gi] <= 1'b1;
          prev[gi] <= 1'b1;
        end else begin
          sync1[gi] <= raw[gi];
          sync2[gi] <= sync1[gi];
          prev[gi] <= sync2[gi]; // RULE19
        end
      end
    end
  endgenerate

  assign keyLow = !sync2[0];
  assign auxHigh = sync2[1];
  assign keyFall = prev[0] && !sync2[0];
  assign auxRise = !prev[1] && sync2[1];
  assign auxFall = prev[1] && !sync2[1];

  // -----------------------------------------------------------------
  // Slow tick
  // -----------------------------------------------------------------
  // One prescaler feeds every ms interval; the 30 us request filter counts clock cycles
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      prescale <= 17'h00000;
      tick <= 1'b0;
    end else if (prescale >= TICK_CYCLES - 17'h00001) begin
      prescale <= 17'h00000;
      tick <= 1'b1; // RULE19
    end else begin
      prescale <= prescale + 17'h00001;
      tick <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // Shutdown request glitch filter
  // -----------------------------------------------------------------
  // Low must persist 30 us; a shorter dip resets the count
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      killCount <= {`PBFSM_KILL_W{1'b0}};
      killLow <= 1'b0;
    end else if (sync2[2]) begin
      killCount <= {`PBFSM_KILL_W{1'b0}};
      killLow <= 1'b0;
    end else if (killCount >= `PBFSM_KILL_CYCLES - 1) begin
      killLow <= 1'b1; // RULE13
    end else begin
      killCount <= killCount + {{(`PBFSM_KILL_W-1){1'b0}}, 1'b1};
    end
  end

  // -----------------------------------------------------------------
  // Interval timer
  // -----------------------------------------------------------------
  // Sixteen oscillator periods; a zero setting leaves only the fixed parts
  assign forcedLimit = {forcedOffDelay, 4'h0}; // RULE9 RULE18 RULE11

  pbfsm_timer uTimer (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .start(ivlStart),
    .tick(tick),
    .limit(ivlLimit),
    .done(ivlDone)
  );

  // The timer's done flag is stale in the cycle its restart is issued
  assign ivlEnd = ivlDone && !ivlStart;

  // Sense fall may end a session only when it began the session
  assign auxOffOk = byAux && auxFalloffAllow && !reducedPin; // RULE1 RULE2 RULE3

  // -----------------------------------------------------------------
  // Sequencer
  // -----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      state <= `PBFSM_S_PWRUP;
      switchOn <= 1'b0;
      byAux <= 1'b0;
      offByAux <= 1'b0;
      auxPend <= 1'b0;
      powerIrqN <= 1'b1;
      ivlStart <= 1'b1;
      ivlLimit <= `PBFSM_LOCKOUT_MS;
    end else begin
      ivlStart <= 1'b0;
      case (state)
        `PBFSM_S_PWRUP: begin
          // Power-up delay, then switch on if the sense input is already high
          if (ivlEnd) begin
            if (auxHigh) begin
              state <= `PBFSM_S_BLANK; // RULE6
              switchOn <= 1'b1;
              byAux <= 1'b1;
              ivlStart <= 1'b1;
              ivlLimit <= `PBFSM_ON_BLANK_MS;
            end else begin
              state <= `PBFSM_S_OFF;
            end
          end
        end
        `PBFSM_S_OFF: begin
          // Only fresh edges turn on; a level left over from turn-off does not
          if (keyFall) begin
            state <= `PBFSM_S_ON_DEB; // RULE4 RULE7
            auxPend <= auxRise;
            ivlStart <= 1'b1;
            ivlLimit <= `PBFSM_DEBOUNCE_MS;
          end else if (auxRise) begin
            state <= `PBFSM_S_BLANK; // RULE7
            switchOn <= 1'b1;
            byAux <= 1'b1;
            ivlStart <= 1'b1;
            ivlLimit <= `PBFSM_ON_BLANK_MS;
          end
        end
        `PBFSM_S_ON_DEB: begin
          // A sense rise seen meanwhile is only remembered
          if (auxRise) begin
            auxPend <= 1'b1; // RULE5
          end
          if (!keyLow) begin
            if ((auxPend || auxRise) && auxHigh) begin
              state <= `PBFSM_S_BLANK; // RULE5
              switchOn <= 1'b1;
              byAux <= 1'b1;
              ivlStart <= 1'b1;
              ivlLimit <= `PBFSM_ON_BLANK_MS;
            end else begin
              state <= `PBFSM_S_OFF;
            end
          end else if (ivlEnd) begin
            state <= `PBFSM_S_BLANK; // RULE15
            switchOn <= 1'b1;
            byAux <= 1'b0;
            ivlStart <= 1'b1;
            ivlLimit <= `PBFSM_ON_BLANK_MS;
          end
        end
        `PBFSM_S_BLANK: begin
          // Inputs ignored; request must be released by the end
          if (ivlEnd) begin
            if (killLow) begin
              state <= `PBFSM_S_HOLD; // RULE16
              switchOn <= 1'b0;
            end else begin
              state <= `PBFSM_S_RUN;
            end
          end
        end
        `PBFSM_S_RUN: begin
          if (killLow) begin
            state <= `PBFSM_S_HOLD; // RULE12
            switchOn <= 1'b0;
          end else if (keyFall) begin
            state <= `PBFSM_S_OFF_DEB;
            ivlStart <= 1'b1;
            ivlLimit <= `PBFSM_DEBOUNCE_MS;
          end else if (auxFall && auxOffOk) begin
            // No debounce on this path, so the forced delay is 32 ms shorter
            state <= `PBFSM_S_IRQ_MIN; // RULE2 RULE10
            offByAux <= 1'b1;
            powerIrqN <= 1'b0;
            ivlStart <= 1'b1;
            ivlLimit <= `PBFSM_IRQ_MIN_MS;
          end
        end
        `PBFSM_S_OFF_DEB: begin
          if (killLow) begin
            state <= `PBFSM_S_HOLD; // RULE12
            switchOn <= 1'b0;
          end else if (!keyLow) begin
            state <= `PBFSM_S_RUN;
          end else if (ivlEnd) begin
            state <= `PBFSM_S_IRQ_MIN; // RULE8
            offByAux <= 1'b0;
            powerIrqN <= 1'b0;
            ivlStart <= 1'b1;
            ivlLimit <= `PBFSM_IRQ_MIN_MS;
          end
        end
        `PBFSM_S_IRQ_MIN: begin
          // Interrupt holds its minimum width even if the source lets go
          if (killLow) begin
            state <= `PBFSM_S_HOLD; // RULE12
            switchOn <= 1'b0;
            powerIrqN <= 1'b1;
          end else if (ivlEnd) begin
            if (offByAux ? !auxHigh : keyLow) begin
              state <= `PBFSM_S_FORCE; // RULE8
              ivlStart <= 1'b1;
              ivlLimit <= forcedLimit;
            end else begin
              state <= `PBFSM_S_RUN;
              powerIrqN <= 1'b1;
            end
          end
        end
        `PBFSM_S_FORCE: begin
          // Releasing the source aborts; a full count forces the supply off
          if (killLow) begin
            state <= `PBFSM_S_HOLD; // RULE12
            switchOn <= 1'b0;
            powerIrqN <= 1'b1;
          end else if (offByAux ? auxHigh : !keyLow) begin
            state <= `PBFSM_S_RUN;
            powerIrqN <= 1'b1;
          end else if (ivlEnd) begin
            state <= `PBFSM_S_HOLD; // RULE18
            switchOn <= 1'b0;
            powerIrqN <= 1'b1;
          end
        end
        `PBFSM_S_HOLD: begin
          // Lockout waits for key release so a held key cannot restart
          byAux <= 1'b0;
          if (!keyLow) begin
            state <= `PBFSM_S_LOCK; // RULE17
            ivlStart <= 1'b1;
            ivlLimit <= `PBFSM_LOCKOUT_MS;
          end
        end
        `PBFSM_S_LOCK: begin
          if (ivlEnd) begin
            state <= `PBFSM_S_OFF; // RULE17
          end
        end
        default: begin
          state <= `PBFSM_S_OFF;
          switchOn <= 1'b0;
          powerIrqN <= 1'b1;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // Output stage
  // -----------------------------------------------------------------
  // Polarity strap is sampled every cycle; changing it live flips the switch
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      supplySwitchOut <= activeLowOut; // RULE14 off in either polarity during reset
      auxGood <= 1'b0;
    end else begin
      supplySwitchOut <= switchOn ^ activeLowOut; // RULE14
      auxGood <= auxHigh;
    end
  end
endmodule // pbfsm_sequencer

// ==== verification/pbfsm_props.sv ====
// Port-level timing checks for the power sequencer.
// Assumes a bind onto pbfsm_sequencer; one clock, synchronous reset.
`timescale 1ns/1ps
module pbfsm_props #(
  parameter [16:0] TICK_CYCLES = 17'd5
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire auxSupplySense,
  input wire activeLowOut,
  input wire supplySwitchOut,
  input wire powerIrqN,
  input wire auxGood
);
  // -------------------------------
  // Helper counters
  // -------------------------------
  // One tick plus two cycles of slack: intervals start off the tick grid
  localparam int BLANK_LO = 511 * TICK_CYCLES - 2;
  localparam int LOCK_LO = 999 * TICK_CYCLES - 2;
  localparam int IRQ_LO = 31 * TICK_CYCLES - 2;
  // Polarity as the output register last took it, so a live change is no switch edge
  logic pol;
  wire on = supplySwitchOut ^ pol;
  int onCnt;
  int offCnt;
  int irqCnt;

  // Length of the current on, off and interrupt spans
  always @(posedge sys_clk) begin
    pol <= activeLowOut;
    if (sys_rst) begin
      onCnt <= 0;
      offCnt <= 0;
      irqCnt <= 0;
    end else begin
      onCnt <= on ? onCnt + 1 : 0;
      offCnt <= on ? 0 : offCnt + 1;
      irqCnt <= powerIrqN ? 0 : irqCnt + 1;
    end
  end

  // -------------------------------
  // Assertions
  // -------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  AST_RST_OFF: assert property (disable iff (1'b0) sys_rst |=> !on && powerIrqN)
    else $error("outputs not idle after reset");
  AST_AUX_HI: assert property (auxSupplySense [*8] |-> auxGood)
    else $error("aux good missed a high sense");
  AST_AUX_LO: assert property (!auxSupplySense [*8] |-> !auxGood)
    else $error("aux good missed a low sense");
  AST_IRQ_ON_ONLY: assert property (!powerIrqN |-> on)
    else $error("interrupt low while switch off");
  AST_ON_MIN: assert property ($fell(on) |-> $past(onCnt) >= BLANK_LO)
    else $error("switch on span shorter than blanking");
  AST_OFF_MIN: assert property ($rose(on) |-> $past(offCnt) >= LOCK_LO)
    else $error("switch off span shorter than lockout");
  // A shutdown request may cut the pulse short, but then the switch drops too
  AST_IRQ_MIN: assert property ($rose(powerIrqN) ##1 on |-> $past(irqCnt, 2) >= IRQ_LO)
    else $error("interrupt pulse too short");
  AST_BLANK_QUIET: assert property (on && onCnt < BLANK_LO |-> powerIrqN)
    else $error("interrupt during blanking");

  // Main scenarios reached
  COV_ON: cover property ($rose(on));
  COV_IRQ: cover property ($fell(powerIrqN));
  COV_OFF: cover property ($fell(on));
endmodule // pbfsm_props

// ==== verification/pbfsm_host_model.sv ====
// Host processor answering the power interrupt on the shutdown request line.
// Assumes the bench sets answerEn and pulseLen between sessions.
`timescale 1ns/1ps
module pbfsm_host_model (
  input wire sys_clk,
  input wire powerIrqN,
  input wire answerEn,
  input wire [15:0] pulseLen,
  output logic shutdownRequestN
);
  // Request idles high so blanking always ends with a live host
  initial begin
    shutdownRequestN = 1'b1;
    forever begin
      @(negedge powerIrqN);
      if (answerEn) begin
        repeat (50) @(posedge sys_clk);
        #1 shutdownRequestN = 1'b0;
        repeat (pulseLen) @(posedge sys_clk);
        #1 shutdownRequestN = 1'b1;
      end
    end
  end
endmodule // pbfsm_host_model

// ==== verification/pushbutton_power_onoff_fsm_tb.sv ====
// Self-checking bench for the pushbutton power sequencer.
// Assumes a 5-cycle tick so every ms interval runs short.
`timescale 1ns/1ps
module pushbutton_power_onoff_fsm_tb;
  localparam [16:0] TICK = 17'd5;
  localparam int LIMIT = 60000;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic pushKeyN = 1'b1;
  logic auxSupplySense = 1'b1;
  logic auxFalloffAllow = 1'b1;
  logic reducedPin = 1'b0;
  logic activeLowOut = 1'b1;
  logic [15:0] forcedOffDelay = 16'h0064;
  logic answerEn = 1'b1;
  logic [15:0] pulseLen = 16'h07d0;
  wire shutdownRequestN;
  wire supplySwitchOut;
  wire powerIrqN;
  wire auxGood;
  int bad_count = 0;
  int cmp_count = 0;
  int cycles = 0;

  // -------------------------------
  // Clock, instances, watchdog
  // -------------------------------
  always #5 sys_clk = ~sys_clk;

  pbfsm_sequencer #(.TICK_CYCLES(TICK)) pbfsm_sequencer_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .pushKeyN(pushKeyN), .auxSupplySense(auxSupplySense), .shutdownRequestN(shutdownRequestN),
    .auxFalloffAllow(auxFalloffAllow), .reducedPin(reducedPin), .activeLowOut(activeLowOut),
    .forcedOffDelay(forcedOffDelay), .supplySwitchOut(supplySwitchOut), .powerIrqN(powerIrqN),
    .auxGood(auxGood));
  pbfsm_host_model pbfsm_host_model_i (.sys_clk(sys_clk), .powerIrqN(powerIrqN), .answerEn(answerEn),
    .pulseLen(pulseLen), .shutdownRequestN(shutdownRequestN));

  // Cut a hang short
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      bad_count++;
      $display("unexpected timeout: expected end seen %0d cycles", cycles);
      end_sim();
    end
  end

  // -------------------------------
  // Shared tasks
  // -------------------------------
  // Inputs move 1 ns after the edge, outputs are settled there too
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic ticks(input int n);
    step(n * TICK);
  endtask
  task automatic chk(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk_on(input logic exp);
    chk("switch", exp ^ activeLowOut, supplySwitchOut);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // -------------------------------
  // Scenarios
  // -------------------------------
  task automatic t_powerup();
    ticks(1010);
    chk_on(1'b1);
    chk("polarity", 1'b0, supplySwitchOut);
    chk("aux good", 1'b1, auxGood);
    $display("powerup done");
  endtask

  // Glitch answer first, abort, then a real answer while sense stays high
  task automatic t_key_off();
    ticks(520);
    pushKeyN = 1'b0;
    ticks(40);
    chk("irq", 1'b0, powerIrqN);
    ticks(440);
    chk_on(1'b1);
    pushKeyN = 1'b1;
    pulseLen = 16'h0c1c;
    ticks(5);
    pushKeyN = 1'b0;
    ticks(40);
    chk("irq", 1'b0, powerIrqN);
    step(3400);
    chk_on(1'b0);
    chk("irq", 1'b1, powerIrqN);
    pushKeyN = 1'b1;
    ticks(1100);
    chk_on(1'b0);
    $display("key off done");
  endtask

  // Key and sense together; key bounce hands over to sense
  task automatic t_both();
    auxSupplySense = 1'b0;
    ticks(5);
    pushKeyN = 1'b0;
    auxSupplySense = 1'b1;
    ticks(20);
    chk_on(1'b0);
    pushKeyN = 1'b1;
    ticks(10);
    chk_on(1'b1);
    $display("both done");
  endtask

  task automatic t_aux_off();
    answerEn = 1'b0;
    forcedOffDelay = 16'h0000;
    ticks(520);
    auxSupplySense = 1'b0;
    step(20);
    chk("irq", 1'b0, powerIrqN);
    ticks(25);
    chk_on(1'b1);
    ticks(6);
    chk_on(1'b0);
    $display("aux off done");
  endtask

  task automatic t_key_on_forced();
    ticks(1010);
    pushKeyN = 1'b0;
    ticks(20);
    pushKeyN = 1'b1;
    ticks(20);
    chk_on(1'b0);
    pushKeyN = 1'b0;
    ticks(40);
    chk_on(1'b1);
    pushKeyN = 1'b1;
    auxSupplySense = 1'b1;
    ticks(520);
    auxSupplySense = 1'b0;
    ticks(40);
    chk("irq", 1'b1, powerIrqN);
    forcedOffDelay = 16'h0002;
    pushKeyN = 1'b0;
    ticks(91);
    chk_on(1'b1);
    ticks(10);
    chk_on(1'b0);
    pushKeyN = 1'b1;
    $display("forced done");
  endtask

  task automatic t_reduced();
    ticks(1010);
    reducedPin = 1'b1;
    auxSupplySense = 1'b1;
    ticks(10);
    chk_on(1'b1);
    ticks(520);
    auxSupplySense = 1'b0;
    ticks(40);
    chk("irq", 1'b1, powerIrqN);
    chk_on(1'b1);
    $display("reduced done");
  endtask

  // Mid-run reset into the active-high variant, sense already high
  task automatic t_polarity();
    sys_rst = 1'b1;
    activeLowOut = 1'b0;
    reducedPin = 1'b0;
    auxSupplySense = 1'b1;
    step(4);
    chk("reset switch", 1'b0, supplySwitchOut);
    chk("reset irq", 1'b1, powerIrqN);
    sys_rst = 1'b0;
    ticks(990);
    chk_on(1'b0);
    ticks(20);
    chk("polarity", 1'b1, supplySwitchOut);
    chk("aux good", 1'b1, auxGood);
    $display("polarity done");
  endtask

  // Main sequence
  initial begin
    step(20);
    sys_rst = 1'b0;
    t_powerup();
    t_key_off();
    t_both();
    t_aux_off();
    t_key_on_forced();
    t_reduced();
    t_polarity();
    end_sim();
  end
endmodule // pushbutton_power_onoff_fsm_tb

bind pbfsm_sequencer pbfsm_props #(.TICK_CYCLES(TICK_CYCLES)) pbfsm_props_i (.sys_clk(sys_clk),
  .sys_rst(sys_rst), .auxSupplySense(auxSupplySense), .activeLowOut(activeLowOut),
  .supplySwitchOut(supplySwitchOut), .powerIrqN(powerIrqN), .auxGood(auxGood));
